// ---- design/ief_frame_gate.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ief_irq_err_map.vh"

module ief_frame_gate (
  // Clock and reset.
  input wire ref_clk_i,
  input wire rst_b_i,
  // Receiver events.
  input wire rx_arm_i,
  input wire rx_sof_i,
  input wire rx_bit_i,
  input wire rx_end_i,
  input wire suppress_i,
  // Frame verdicts.
  output reg short_frame_o,
  output reg discard_o,
  output reg rx_done_o,
  output reg decoder_enable_o
);

  reg [7:0] bit_cnt_r;
  reg in_frame_r;
  wire too_short;
  wire too_short_suppr;

  assign too_short = bit_cnt_r < `IEF_MIN_FRAME_BITS;
  assign too_short_suppr = suppress_i && (bit_cnt_r < `IEF_MIN_SUPPR_BITS);

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_r <= 8'h00;
      in_frame_r <= 1'b0;
      short_frame_o <= 1'b0;
      discard_o <= 1'b0;
      rx_done_o <= 1'b0;
      decoder_enable_o <= 1'b0;
    end else begin
      short_frame_o <= 1'b0;
      discard_o <= 1'b0;
      rx_done_o <= 1'b0;
      if (rx_arm_i) begin
        decoder_enable_o <= 1'b1;
      end
      if (rx_sof_i) begin
        in_frame_r <= 1'b1;
        bit_cnt_r <= 8'h00;
      end else if (in_frame_r && rx_end_i) begin
        in_frame_r <= 1'b0;
        if (too_short || too_short_suppr) begin
          short_frame_o <= too_short;
          discard_o <= 1'b1;
        end else begin
          rx_done_o <= 1'b1;
          decoder_enable_o <= 1'b0;
        end
      end else if (in_frame_r && rx_bit_i && bit_cnt_r != 8'hFF) begin
        bit_cnt_r <= bit_cnt_r + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/ief_irq1_err.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ief_irq_err_map.vh"

module ief_irq1_err (
  // Clock and reset.
  input wire ref_clk_i,
  input wire rst_b_i,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Interrupt sources.
  input wire [4:0] timer_underflow_i,
  input wire card_detect_i,
  input wire other_irq_pending_i,
  input wire error_irq_clear_i,
  // EEPROM command status.
  input wire eeprom_cmd_done_i,
  input wire eeprom_cmd_fail_i,
  // FIFO write path.
  input wire fifo_write_i,
  input wire [7:0] fifo_wdata_i,
  input wire fifo_full_i,
  input wire fifo_empty_i,
  input wire fifo_flush_i,
  output reg fifo_push_o,
  output reg [7:0] fifo_push_data_o,
  // Contactless command state.
  input wire [2:0] com_state_i,
  input wire crc_tx_i,
  input wire auth_cmd_i,
  input wire cl_cmd_start_i,
  input wire multi_frame_receive_i,
  input wire err_flags_stored_i,
  input wire rx_cmd_start_i,
  input wire wait_data_entry_i,
  input wire tx_due_i,
  // Receiver events.
  input wire rx_sof_i,
  input wire rx_bit_i,
  input wire rx_end_i,
  input wire disturbance_suppression_i,
  input wire collision_i,
  input wire protocol_error_i,
  input wire integrity_error_i,
  // Flag outputs.
  output reg combined_interrupt_flag_o,
  output reg error_interrupt_flag_o,
  output reg reception_complete_o,
  output reg frame_discard_o,
  output reg receive_decoder_o,
  // Interrupt pin.
  output reg irq_pin_o,
  output reg irq_pin_oe_o,
  // Event interrupt.
  output reg evt_irq_o
);

  reg [7:0] irq1_en_r;
  reg [5:0] irq1_flags_r;
  reg [5:0] irq1_flags_nxt;
  reg [7:0] err_r;
  reg [7:0] err_nxt;
  reg [`IEF_EVT_WIDTH-1:0] evt_status_r;
  reg [`IEF_EVT_WIDTH-1:0] evt_status_nxt;
  reg [`IEF_EVT_WIDTH-1:0] evt_enable_r;
  reg err_irq_r;
  reg [7:0] rdata_nxt;
  wire [5:0] flag_events;
  wire [5:0] enabled_flags;
  wire combined_nxt;
  wire busy_write;
  wire write_error_set;
  wire write_error_clear;
  wire overflow_set;
  wire short_frame;
  wire discard;
  wire rx_done;
  wire decoder_en;
  wire [7:0] err_rise;
  wire err_irq_set;
  wire pin_active;
  wire irq1_wr;
  wire [`IEF_EVT_WIDTH-1:0] evt_set;

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    input strobe;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  ief_frame_gate u_frame_gate (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .rx_arm_i(rx_cmd_start_i | wait_data_entry_i),
    .rx_sof_i(rx_sof_i),
    .rx_bit_i(rx_bit_i),
    .rx_end_i(rx_end_i),
    .suppress_i(disturbance_suppression_i),
    .short_frame_o(short_frame),
    .discard_o(discard),
    .rx_done_o(rx_done),
    .decoder_enable_o(decoder_en)
  );

  assign flag_events = {card_detect_i, timer_underflow_i};
  assign irq1_wr = hit(reg_addr_i, `IEF_OFS_IRQ1, reg_wr_i);

  // Request flags: hardware set wins over a software clear.
  always @* begin
    irq1_flags_nxt = irq1_flags_r;
    if (irq1_wr) begin
      if (reg_wdata_i[`IEF_IRQ1_SET]) begin
        irq1_flags_nxt = irq1_flags_r | reg_wdata_i[5:0];
      end else begin
        irq1_flags_nxt = irq1_flags_r & ~reg_wdata_i[5:0];
      end
    end
    irq1_flags_nxt = irq1_flags_nxt | flag_events;
  end

  // Each timer and card detect source passes to the combined flag through its own enable bit; other_irq_pending_i passes ungated.
  genvar gi;
  generate
    for (gi = 0; gi < `IEF_NUM_TIMERS; gi = gi + 1) begin : g_timer_gate
      assign enabled_flags[gi] = irq1_flags_r[gi] & irq1_en_r[gi];
    end
  endgenerate
  assign enabled_flags[`IEF_EN_CARD_DETECT] =
    irq1_flags_r[`IEF_EN_CARD_DETECT] & irq1_en_r[`IEF_EN_CARD_DETECT];
  assign combined_nxt = (|enabled_flags) | other_irq_pending_i;

  // Error flag sources.
  assign busy_write = crc_tx_i || auth_cmd_i || (com_state_i == `IEF_ST_RX_WAIT) ||
    (com_state_i == `IEF_ST_WAIT_DATA) || (com_state_i == `IEF_ST_RECEIVING);
  assign write_error_set = fifo_write_i && busy_write;
  assign write_error_clear = multi_frame_receive_i ? err_flags_stored_i : cl_cmd_start_i;
  assign overflow_set = fifo_write_i && fifo_full_i;

  always @* begin
    err_nxt = err_r;
    if (eeprom_cmd_done_i) begin
      err_nxt[`IEF_ERR_EEPROM] = eeprom_cmd_fail_i;
    end
    if (write_error_clear) begin
      err_nxt[`IEF_ERR_FIFO_WRITE] = 1'b0;
    end
    if (write_error_set) begin
      err_nxt[`IEF_ERR_FIFO_WRITE] = 1'b1;
    end
    if (fifo_flush_i) begin
      err_nxt[`IEF_ERR_FIFO_OVERFLOW] = 1'b0;
    end
    if (overflow_set) begin
      err_nxt[`IEF_ERR_FIFO_OVERFLOW] = 1'b1;
    end
    if (rx_cmd_start_i || wait_data_entry_i) begin
      err_nxt[`IEF_ERR_SHORT_FRAME] = 1'b0;
      err_nxt[`IEF_ERR_COLLISION] = 1'b0;
      err_nxt[`IEF_ERR_PROTOCOL] = 1'b0;
      err_nxt[`IEF_ERR_INTEGRITY] = 1'b0;
    end
    if (short_frame) begin
      err_nxt[`IEF_ERR_SHORT_FRAME] = 1'b1;
    end
    if (cl_cmd_start_i) begin
      err_nxt[`IEF_ERR_MISSING_DATA] = 1'b0;
    end
    if (tx_due_i && fifo_empty_i) begin
      err_nxt[`IEF_ERR_MISSING_DATA] = 1'b1;
    end
    if (collision_i) begin
      err_nxt[`IEF_ERR_COLLISION] = 1'b1;
    end
    if (protocol_error_i) begin
      err_nxt[`IEF_ERR_PROTOCOL] = 1'b1;
    end
    if (integrity_error_i) begin
      err_nxt[`IEF_ERR_INTEGRITY] = 1'b1;
    end
  end

  assign err_rise = err_nxt & ~err_r;
  assign err_irq_set = err_rise[`IEF_ERR_FIFO_WRITE] | err_rise[`IEF_ERR_FIFO_OVERFLOW] |
    err_rise[`IEF_ERR_PROTOCOL] | err_rise[`IEF_ERR_MISSING_DATA] |
    err_rise[`IEF_ERR_INTEGRITY];

  // Pin is asserted low; only an enabled combined flag may assert it.
  assign pin_active = combined_interrupt_flag_o & irq1_en_r[`IEF_EN_PIN_ENABLE];

  // Block events for the local interrupt output.
  assign evt_set[`IEF_EVT_ERROR] = err_irq_set;
  assign evt_set[`IEF_EVT_COMBINED] = combined_nxt & ~combined_interrupt_flag_o;
  assign evt_set[`IEF_EVT_DISCARD] = discard;
  assign evt_set[`IEF_EVT_EEPROM] = err_rise[`IEF_ERR_EEPROM];

  always @* begin
    evt_status_nxt = evt_status_r;
    if (hit(reg_addr_i, `IEF_OFS_EVT_CLEAR, reg_wr_i)) begin
      evt_status_nxt = evt_status_r & ~reg_wdata_i[`IEF_EVT_WIDTH-1:0];
    end
    evt_status_nxt = evt_status_nxt | evt_set;
  end

  // Read data mux; unmapped addresses read as zero.
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `IEF_OFS_IRQ1: begin
        rdata_nxt = {1'b0, combined_interrupt_flag_o, irq1_flags_r};
      end
      `IEF_OFS_IRQ1_EN: begin
        rdata_nxt = irq1_en_r;
      end
      `IEF_OFS_ERROR: begin
        rdata_nxt = err_r;
      end
      `IEF_OFS_EVT_STATUS: begin
        rdata_nxt = {4'h0, evt_status_r};
      end
      `IEF_OFS_EVT_ENABLE: begin
        rdata_nxt = {4'h0, evt_enable_r};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq1_en_r <= `IEF_RST_IRQ1_EN;
      irq1_flags_r <= 6'h00;
      err_r <= `IEF_RST_ERROR;
      err_irq_r <= 1'b0;
      evt_status_r <= {`IEF_EVT_WIDTH{1'b0}};
      evt_enable_r <= `IEF_RST_EVT_ENABLE;
      reg_rdata_o <= 8'h00;
      fifo_push_o <= 1'b0;
      fifo_push_data_o <= 8'h00;
      combined_interrupt_flag_o <= 1'b0;
      error_interrupt_flag_o <= 1'b0;
      reception_complete_o <= 1'b0;
      frame_discard_o <= 1'b0;
      receive_decoder_o <= 1'b0;
      irq_pin_o <= 1'b1;
      irq_pin_oe_o <= 1'b0;
      evt_irq_o <= 1'b0;
    end else begin
      if (hit(reg_addr_i, `IEF_OFS_IRQ1_EN, reg_wr_i)) begin
        irq1_en_r <= reg_wdata_i;
      end
      if (hit(reg_addr_i, `IEF_OFS_EVT_ENABLE, reg_wr_i)) begin
        evt_enable_r <= reg_wdata_i[`IEF_EVT_WIDTH-1:0];
      end
      irq1_flags_r <= irq1_flags_nxt;
      err_r <= err_nxt;
      evt_status_r <= evt_status_nxt;
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
      // Full or overflowed FIFO refuses the write and keeps its contents.
      fifo_push_o <= fifo_write_i && !fifo_full_i && !err_r[`IEF_ERR_FIFO_OVERFLOW];
      if (fifo_write_i) begin
        fifo_push_data_o <= fifo_wdata_i;
      end
      combined_interrupt_flag_o <= combined_nxt;
      if (err_irq_set) begin
        err_irq_r <= 1'b1;
      end else if (error_irq_clear_i) begin
        err_irq_r <= 1'b0;
      end
      error_interrupt_flag_o <= err_irq_r;
      reception_complete_o <= rx_done;
      frame_discard_o <= discard;
      receive_decoder_o <= decoder_en;
      if (irq1_en_r[`IEF_EN_OUTPUT_STYLE]) begin
        irq_pin_o <= ~pin_active;
        irq_pin_oe_o <= 1'b1;
      end else begin
        irq_pin_o <= 1'b0;
        irq_pin_oe_o <= pin_active;
      end
      evt_irq_o <= |(evt_status_nxt & evt_enable_r);
    end
  end

endmodule

`default_nettype wire

// ---- design/ief_irq_err_map.vh ----
`ifndef IEF_IRQ_ERR_MAP_VH
`define IEF_IRQ_ERR_MAP_VH

// Register offsets.
`define IEF_OFS_IRQ1 8'h07
`define IEF_OFS_IRQ1_EN 8'h09
`define IEF_OFS_ERROR 8'h0A
`define IEF_OFS_EVT_STATUS 8'h20
`define IEF_OFS_EVT_CLEAR 8'h21
`define IEF_OFS_EVT_ENABLE 8'h22

// Reset values.
`define IEF_RST_IRQ1_EN 8'h00
`define IEF_RST_ERROR 8'h00
`define IEF_RST_EVT_ENABLE 4'h0

// Field positions of the second enable register.
`define IEF_EN_OUTPUT_STYLE 7
`define IEF_EN_PIN_ENABLE 6
`define IEF_EN_CARD_DETECT 5
`define IEF_NUM_TIMERS 5

// Field positions of the second request register.
`define IEF_IRQ1_SET 7
`define IEF_IRQ1_COMBINED 6

// Field positions of the error register.
`define IEF_ERR_EEPROM 7
`define IEF_ERR_FIFO_WRITE 6
`define IEF_ERR_FIFO_OVERFLOW 5
`define IEF_ERR_SHORT_FRAME 4
`define IEF_ERR_MISSING_DATA 3
`define IEF_ERR_COLLISION 2
`define IEF_ERR_PROTOCOL 1
`define IEF_ERR_INTEGRITY 0

// Event status bit positions.
`define IEF_EVT_ERROR 0
`define IEF_EVT_COMBINED 1
`define IEF_EVT_DISCARD 2
`define IEF_EVT_EEPROM 3
`define IEF_EVT_WIDTH 4

// Communication state codes.
`define IEF_ST_RX_WAIT 3'h5
`define IEF_ST_WAIT_DATA 3'h6
`define IEF_ST_RECEIVING 3'h7

// Frame length limits.
`define IEF_MIN_FRAME_BITS 8'h04
`define IEF_MIN_SUPPR_BITS 8'h18

`endif

// ---- test/ief_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ief_host_model (
  // Pin from the block.
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // Host view.
  output logic level_o,
  output logic irq_seen_o
);
  // A released pin is pulled high.
  assign level_o = pin_oe_i ? pin_i : 1'h1;
  assign irq_seen_o = !level_o;
endmodule
`default_nettype wire

// ---- test/ief_irq1_err_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ief_irq1_err_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Watched inputs.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] timer_underflow_i,
  input wire logic card_detect_i,
  input wire logic other_irq_pending_i,
  input wire logic rx_sof_i,
  input wire logic rx_bit_i,
  input wire logic rx_end_i,
  input wire logic disturbance_suppression_i,
  // Watched outputs.
  input wire logic combined_interrupt_flag_o,
  input wire logic reception_complete_o,
  input wire logic frame_discard_o,
  input wire logic receive_decoder_o,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_o
);
  logic [7:0] en_r;

  // Mirror of the second enable register.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 8'h09) begin
      en_r <= reg_wdata_i;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_short;
    rx_sof_i ##1 rx_bit_i [*3] ##1 rx_end_i;
  endsequence
  sequence s_good;
    rx_sof_i ##1 rx_bit_i [*4] ##1 (rx_end_i && !disturbance_suppression_i);
  endsequence
  sequence s_sup;
    rx_sof_i ##1 rx_bit_i [*8] ##1 (rx_end_i && disturbance_suppression_i);
  endsequence

  a_push_pull: assert property ($past(rst_b_i) && $past(en_r[7]) |-> irq_pin_oe_o)
    else $error("pin released in push-pull style");
  a_open_drain: assert property ($past(rst_b_i) && !$past(en_r[7]) |-> !irq_pin_o)
    else $error("pin driven high in open-drain style");
  a_pin_gate: assert property ($past(rst_b_i) |-> (irq_pin_oe_o && !irq_pin_o) ==
    ($past(combined_interrupt_flag_o) && $past(en_r[6])))
    else $error("pin level does not follow gated flag");
  a_timer_feed: assert property ((timer_underflow_i & en_r[4:0]) != 5'h00 |-> ##2 combined_interrupt_flag_o)
    else $error("enabled timer did not set combined flag");
  a_card_feed: assert property (card_detect_i && en_r[5] |-> ##2 combined_interrupt_flag_o)
    else $error("enabled card detect did not set combined flag");
  a_quiet_comb: assert property (en_r[5:0] == 6'h00 && !other_irq_pending_i |=> !combined_interrupt_flag_o)
    else $error("combined flag without enabled source");
  a_short_drop: assert property (s_short |-> ##2 (frame_discard_o && !reception_complete_o && receive_decoder_o))
    else $error("short frame not dropped");
  a_frame_done: assert property (s_good |-> ##2 (reception_complete_o && !frame_discard_o))
    else $error("four bit frame not completed");
  a_sup_drop: assert property (s_sup |-> ##2 (frame_discard_o && !reception_complete_o))
    else $error("suppressed short frame not dropped");
endmodule
bind ief_irq1_err ief_irq1_err_chk ief_irq1_err_chk_i (.*);
`default_nettype wire

// ---- test/ief_irq1_err_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ief_irq1_err_test;
  typedef struct packed {logic [7:0] en; logic [4:0] tmr; logic card; logic comb;} ief_row_t;
  localparam int P_CLR = 8, P_CL = 7, P_RX = 6, P_WD = 5, P_FS = 4, P_EE = 3, P_TX = 2, P_PE = 1, P_FL = 0;
  logic ref_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic [7:0] reg_addr_i, reg_wdata_i, fifo_wdata_i;
  logic [4:0] timer_underflow_i;
  logic [2:0] com_state_i;
  logic reg_wr_i, reg_rd_i, card_detect_i, fifo_write_i, fifo_full_i, fifo_empty_i, auth_cmd_i;
  logic eeprom_cmd_fail_i, multi_frame_receive_i, rx_sof_i, rx_bit_i, rx_end_i, disturbance_suppression_i;
  logic crc_tx_i;
  logic [8:0] pl;
  wire logic error_irq_clear_i, cl_cmd_start_i, rx_cmd_start_i, wait_data_entry_i, err_flags_stored_i;
  wire logic eeprom_cmd_done_i, tx_due_i, protocol_error_i, fifo_flush_i;
  wire logic other_irq_pending_i = 1'h0, collision_i = 1'h0, integrity_error_i = 1'h0;
  wire logic [7:0] reg_rdata_o, fifo_push_data_o;
  wire logic fifo_push_o, combined_interrupt_flag_o, error_interrupt_flag_o, reception_complete_o;
  wire logic frame_discard_o, receive_decoder_o, irq_pin_o, irq_pin_oe_o, evt_irq_o, level, irq_seen;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  ief_row_t rows [7] = '{'{8'h41, 5'h01, 1'h0, 1'h1}, '{8'hC2, 5'h01, 1'h0, 1'h0},
    '{8'h90, 5'h10, 1'h0, 1'h1}, '{8'h60, 5'h00, 1'h1, 1'h1}, '{8'h48, 5'h08, 1'h0, 1'h1},
    '{8'h44, 5'h1B, 1'h0, 1'h0}, '{8'h1F, 5'h00, 1'h1, 1'h0}};

  assign {error_irq_clear_i, cl_cmd_start_i, rx_cmd_start_i, wait_data_entry_i, err_flags_stored_i,
    eeprom_cmd_done_i, tx_due_i, protocol_error_i, fifo_flush_i} = pl;

  ief_irq1_err ief_irq1_err_i (.*);
  ief_host_model ief_host_model_i (.pin_i(irq_pin_o), .pin_oe_i(irq_pin_oe_o), .level_o(level),
    .irq_seen_o(irq_seen));

  always #5 ref_clk_i = ~ref_clk_i;

  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      test_done();
    end
  end

  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'h1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h0;
  endtask

  task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    chk(reg_rdata_o & m, e);
  endtask

  task pulse(input int b);
    @(posedge ref_clk_i);
    pl[b] <= 1'h1;
    @(posedge ref_clk_i);
    pl <= 9'h000;
    tick(3);
  endtask

  task fw(input logic [7:0] v);
    @(posedge ref_clk_i);
    fifo_write_i <= 1'h1;
    fifo_wdata_i <= v;
    @(posedge ref_clk_i);
    fifo_write_i <= 1'h0;
    #1;
  endtask

  task frm(input int n, input logic s);
    disturbance_suppression_i <= s;
    @(posedge ref_clk_i);
    rx_sof_i <= 1'h1;
    @(posedge ref_clk_i);
    rx_sof_i <= 1'h0;
    rx_bit_i <= 1'h1;
    repeat (n) @(posedge ref_clk_i);
    rx_bit_i <= 1'h0;
    rx_end_i <= 1'h1;
    @(posedge ref_clk_i);
    rx_end_i <= 1'h0;
    tick(4);
  endtask

  initial begin
    {reg_addr_i, reg_wdata_i, fifo_wdata_i, timer_underflow_i, com_state_i, reg_wr_i, reg_rd_i, card_detect_i,
      fifo_write_i, fifo_full_i, fifo_empty_i, auth_cmd_i, eeprom_cmd_fail_i, multi_frame_receive_i,
      rx_sof_i, rx_bit_i, rx_end_i, disturbance_suppression_i, crc_tx_i, pl} = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    rc(8'h09, 8'hFF, 8'h00);
    wr(8'h0A, 8'hFF);
    rc(8'h0A, 8'hFF, 8'h00);
    rc(8'h30, 8'hFF, 8'h00);
    foreach (rows[i]) begin
      wr(8'h07, 8'h3F);
      wr(8'h09, rows[i].en);
      @(posedge ref_clk_i);
      timer_underflow_i <= rows[i].tmr;
      card_detect_i <= rows[i].card;
      @(posedge ref_clk_i);
      timer_underflow_i <= 5'h00;
      card_detect_i <= 1'h0;
      tick(4);
      chk(combined_interrupt_flag_o, rows[i].comb);
      chk(irq_seen, rows[i].comb & rows[i].en[6]);
      chk({irq_pin_oe_o, irq_pin_o}, rows[i].en[7] ? {1'h1, !(rows[i].comb & rows[i].en[6])} :
        {rows[i].comb & rows[i].en[6], 1'h0});
      rc(8'h09, 8'hFF, rows[i].en);
    end
    // Event interrupt: raise, mask, clear.
    wr(8'h22, 8'h01);
    pulse(P_RX);
    pulse(P_PE);
    tick(3);
    chk(error_interrupt_flag_o, 1'h1);
    chk(evt_irq_o, 1'h1);
    rc(8'h20, 8'h01, 8'h01);
    wr(8'h22, 8'h00);
    tick(2);
    chk(evt_irq_o, 1'h0);
    wr(8'h21, 8'h0F);
    rc(8'h20, 8'h01, 8'h00);
    pulse(P_CLR);
    chk(error_interrupt_flag_o, 1'h0);
    eeprom_cmd_fail_i <= 1'h1;
    pulse(P_EE);
    rc(8'h0A, 8'h80, 8'h80);
    eeprom_cmd_fail_i <= 1'h0;
    pulse(P_EE);
    rc(8'h0A, 8'h80, 8'h00);
    fw(8'hA5);
    chk({fifo_push_o, fifo_push_data_o}, 9'h1A5);
    fifo_full_i <= 1'h1;
    fw(8'h3C);
    chk(fifo_push_o, 1'h0);
    fifo_full_i <= 1'h0;
    rc(8'h0A, 8'h20, 8'h20);
    fw(8'h5A);
    chk(fifo_push_o, 1'h0);
    pulse(P_FL);
    fw(8'h66);
    chk({fifo_push_o, fifo_push_data_o}, 9'h166);
    for (int k = 0; k < 4; k++) begin
      com_state_i <= 3'(5 + k);
      auth_cmd_i <= (k == 3);
      fw(8'h11);
      {com_state_i, auth_cmd_i} <= 4'h0;
      rc(8'h0A, 8'h40, 8'h40);
      pulse(P_CL);
      rc(8'h0A, 8'h40, 8'h00);
    end
    crc_tx_i <= 1'h1;
    fw(8'h12);
    crc_tx_i <= 1'h0;
    rc(8'h0A, 8'h40, 8'h40);
    pulse(P_CL);
    rc(8'h0A, 8'h40, 8'h00);
    multi_frame_receive_i <= 1'h1;
    com_state_i <= 3'h7;
    fw(8'h22);
    com_state_i <= 3'h0;
    pulse(P_FS);
    rc(8'h0A, 8'h40, 8'h00);
    multi_frame_receive_i <= 1'h0;
    fifo_empty_i <= 1'h1;
    pulse(P_TX);
    fifo_empty_i <= 1'h0;
    rc(8'h0A, 8'h08, 8'h08);
    pulse(P_RX);
    frm(3, 1'h0);
    rc(8'h0A, 8'h10, 8'h10);
    chk(receive_decoder_o, 1'h1);
    frm(8, 1'h1);
    chk(receive_decoder_o, 1'h1);
    frm(4, 1'h0);
    pulse(P_RX);
    rc(8'h0A, 8'h10, 8'h00);
    frm(2, 1'h0);
    rc(8'h0A, 8'h10, 8'h10);
    pulse(P_WD);
    rc(8'h0A, 8'h10, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
